// >>> logic/asp_pkg.sv
// Constants, register map and state types of the async serial port
`default_nettype none
package asp_pkg;
   localparam int ASP_AW = 5;
   localparam logic [ASP_AW-1:0] ASP_OFS_DATA = 5'h00;
   localparam logic [ASP_AW-1:0] ASP_OFS_CTRL1 = 5'h04;
   localparam logic [ASP_AW-1:0] ASP_OFS_CTRL2 = 5'h08;
   localparam logic [ASP_AW-1:0] ASP_OFS_STATUS = 5'h0C;
   localparam logic [ASP_AW-1:0] ASP_OFS_BAUD = 5'h10;
   localparam logic [1:0] ASP_RESP_OKAY = 2'h0;
   localparam logic [1:0] ASP_RESP_SLVERR = 2'h2;
   localparam logic [7:0] ASP_CTRL1_RST = 8'h00;
   localparam logic [7:0] ASP_CTRL2_RST = 8'h00;
   localparam logic [4:0] ASP_BAUD_RST = 5'h00;
   localparam logic [3:0] ASP_RT_PER_BIT = 4'hF;
   localparam logic [3:0] ASP_RT_V1 = 4'h3;
   localparam logic [3:0] ASP_RT_V2 = 4'h5;
   localparam logic [3:0] ASP_RT_V3 = 4'h7;
   localparam logic [3:0] ASP_RT_S1 = 4'h8;
   localparam logic [3:0] ASP_RT_S2 = 4'h9;
   localparam logic [3:0] ASP_RT_S3 = 4'hA;
   localparam logic [3:0] ASP_RT_LAST = 4'h0;
   localparam logic [3:0] ASP_BITS8 = 4'hA;
   localparam logic [3:0] ASP_BITS9 = 4'hB;
   localparam int ASP_C1_R8 = 7;
   localparam int ASP_C1_T8 = 6;
   localparam int ASP_C1_M = 4;
   localparam int ASP_C1_WAKE = 3;
   localparam int ASP_C2_TIE = 7;
   localparam int ASP_C2_TCIE = 6;
   localparam int ASP_C2_RIE = 5;
   localparam int ASP_C2_ILIE = 4;
   localparam int ASP_C2_TE = 3;
   localparam int ASP_C2_RE = 2;
   localparam int ASP_C2_RWU = 1;
   localparam int ASP_C2_SBK = 0;
   localparam int ASP_ST_TDRE = 7;
   localparam int ASP_ST_TC = 6;
   localparam int ASP_ST_RX_FULL_FLAG = 5;
   localparam int ASP_ST_IDLE = 4;
   localparam int ASP_ST_OR = 3;
   localparam int ASP_ST_NF = 2;
   localparam int ASP_ST_FE = 1;
   typedef enum logic [1:0] {ASP_R_IDLE, ASP_R_START, ASP_R_BITS,
      ASP_R_FWAIT} asp_rx_state_t;
   typedef enum logic [0:0] {ASP_T_IDLE, ASP_T_SHIFT} asp_tx_state_t;
   typedef struct packed {
      logic tdre;
      logic tc;
      logic rx_full_flag;
      logic idle;
      logic ovr;
      logic nf;
      logic fe;
   } asp_flags_t;
endpackage : asp_pkg
`default_nettype wire

// >>> logic/asp_top.sv
// Async serial port with AXI4-Lite register slave
`default_nettype none
module asp_top
(
   input wire logic ref_clk, // 10 MHz clock
   input wire logic reset_n, // Async reset, active low
   input wire logic [asp_pkg::ASP_AW-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [asp_pkg::ASP_AW-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic serial_rx_pin, // Serial line in
   output logic serial_tx_pin, // Serial line out
   output logic irq // Port interrupt, active high level
);
   import asp_pkg::*;

   typedef struct packed {
      logic rx_s1;
      logic rx_s2;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_got;
      logic w_got;
      logic [ASP_AW-1:0] waddr;
      logic [7:0] wdata;
      logic wstrb0;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [4:0] baud;
      asp_flags_t fl;
      logic [7:0] tx_data;
      logic [7:0] rx_data;
      logic [4:0] rt_div;
      asp_rx_state_t rs;
      logic [3:0] rx_rt;
      logic [3:0] rx_bit;
      logic [1:0] vhigh;
      logic [2:0] smp;
      logic rx_noise;
      logic [8:0] rx_sh;
      logic armed;
      logic [7:0] idle_cnt;
      logic idle_pend;
      asp_tx_state_t ts;
      logic [3:0] tx_rt;
      logic [3:0] tx_bit;
      logic [10:0] tx_sh;
      logic tx_pin;
      logic irq;
   } asp_state_t;

   asp_state_t s;
   asp_state_t next_s;

   function automatic logic asp_major(input logic [2:0] v);
      asp_major = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction : asp_major

   function automatic logic asp_mapped(input logic [ASP_AW-1:0] a);
      if (a == ASP_OFS_DATA)
         asp_mapped = 1'b1;
      else if (a == ASP_OFS_CTRL1)
         asp_mapped = 1'b1;
      else if (a == ASP_OFS_CTRL2)
         asp_mapped = 1'b1;
      else if (a == ASP_OFS_STATUS)
         asp_mapped = 1'b1;
      else if (a == ASP_OFS_BAUD)
         asp_mapped = 1'b1;
      else
         asp_mapped = 1'b0;
   endfunction : asp_mapped

   logic line;
   logic rt_tick;
   logic tx_tick;
   logic nine;
   logic [3:0] nbits;
   logic [7:0] idle_target;
   logic maj;
   logic disagree;
   logic brk;
   logic accept;
   logic tx_go;
   logic [10:0] tx_frame;
   logic [7:0] sbits;

   always_comb
   begin
      next_s = s;
      line = s.rx_s2;
      nine = s.ctrl1[ASP_C1_M];
      nbits = nine ? ASP_BITS9 : ASP_BITS8;
      idle_target = {nbits, 4'h0} - 8'h01;
      rt_tick = (s.rt_div == s.baud);
      tx_tick = rt_tick && (s.tx_rt == ASP_RT_PER_BIT);
      maj = asp_major(s.smp);
      disagree = (s.smp != 3'h0) && (s.smp != 3'h7);
      brk = 1'b0;
      accept = 1'b0;
      tx_go = 1'b0;
      tx_frame = 11'h000;
      sbits = {s.fl.tdre, s.fl.tc, s.fl.rx_full_flag, s.fl.idle, s.fl.ovr,
         s.fl.nf, s.fl.fe, 1'b0};

      // Pin synchroniser
      next_s.rx_s1 = serial_rx_pin;
      next_s.rx_s2 = s.rx_s1;

      // Bus: read channel
      if (s.arready && s_axi_arvalid)
      begin
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rresp = asp_mapped(s_axi_araddr) ? ASP_RESP_OKAY
            : ASP_RESP_SLVERR;
         next_s.rdata = 32'h0000_0000;
         if (s_axi_araddr == ASP_OFS_DATA)
         begin
            next_s.rdata[7:0] = s.rx_data;
            next_s.fl.rx_full_flag = 1'b0;
         end
         else if (s_axi_araddr == ASP_OFS_CTRL1)
            next_s.rdata[7:0] = s.ctrl1;
         else if (s_axi_araddr == ASP_OFS_CTRL2)
            next_s.rdata[7:0] = s.ctrl2;
         else if (s_axi_araddr == ASP_OFS_STATUS)
            next_s.rdata[7:0] = sbits;
         else if (s_axi_araddr == ASP_OFS_BAUD)
            next_s.rdata[4:0] = s.baud;
      end
      if (s.rvalid && s_axi_rready)
      begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end

      // Bus: write channels, taken in either order
      if (s.awready && s_axi_awvalid)
      begin
         next_s.awready = 1'b0;
         next_s.aw_got = 1'b1;
         next_s.waddr = s_axi_awaddr;
      end
      if (s.wready && s_axi_wvalid)
      begin
         next_s.wready = 1'b0;
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata[7:0];
         next_s.wstrb0 = s_axi_wstrb[0];
      end
      if (s.aw_got && s.w_got && !s.bvalid)
      begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = asp_mapped(s.waddr) ? ASP_RESP_OKAY
            : ASP_RESP_SLVERR;
         if (s.wstrb0)
         begin
            if (s.waddr == ASP_OFS_DATA)
            begin
               next_s.tx_data = s.wdata;
               next_s.fl.tdre = 1'b0;
               next_s.fl.tc = 1'b0;
            end
            else if (s.waddr == ASP_OFS_CTRL1)
            begin
               next_s.ctrl1[ASP_C1_T8] = s.wdata[ASP_C1_T8];
               next_s.ctrl1[ASP_C1_M] = s.wdata[ASP_C1_M];
               next_s.ctrl1[ASP_C1_WAKE] = s.wdata[ASP_C1_WAKE];
            end
            else if (s.waddr == ASP_OFS_CTRL2)
               next_s.ctrl2 = s.wdata;
            else if (s.waddr == ASP_OFS_STATUS)
            begin
               if (s.wdata[ASP_ST_IDLE])
                  next_s.fl.idle = 1'b0;
               if (s.wdata[ASP_ST_OR])
                  next_s.fl.ovr = 1'b0;
               if (s.wdata[ASP_ST_NF])
                  next_s.fl.nf = 1'b0;
               if (s.wdata[ASP_ST_FE])
                  next_s.fl.fe = 1'b0;
            end
            else if (s.waddr == ASP_OFS_BAUD)
            begin
               next_s.baud = s.wdata[4:0];
               next_s.rt_div = 5'h00;
            end
         end
      end
      if (s.bvalid && s_axi_bready)
      begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end

      // Sample tick divider
      if (rt_tick)
         next_s.rt_div = 5'h00;
      else if (!(s.bvalid == 1'b0 && s.aw_got && s.w_got
         && s.waddr == ASP_OFS_BAUD && s.wstrb0))
         next_s.rt_div = s.rt_div + 5'h01;

      // Receiver, one step per sample tick
      if (!s.ctrl2[ASP_C2_RE])
      begin
         next_s.rs = ASP_R_IDLE;
         next_s.armed = 1'b0;
         next_s.idle_cnt = 8'h00;
      end
      else if (rt_tick)
      begin
         // Idle string detection and idle-line wake-up
         if (!line)
            next_s.idle_cnt = 8'h00;
         else if (s.idle_cnt != 8'hFF)
            next_s.idle_cnt = s.idle_cnt + 8'h01;
         if (line && s.idle_cnt == idle_target)
         begin
            if (s.ctrl2[ASP_C2_RWU] && !s.ctrl1[ASP_C1_WAKE])
               next_s.ctrl2[ASP_C2_RWU] = 1'b0;
            else if (!s.ctrl2[ASP_C2_RWU] && s.idle_pend)
               next_s.fl.idle = 1'b1;
            next_s.idle_pend = 1'b0;
         end
         next_s.rx_rt = s.rx_rt + 4'h1;
         if (s.rx_rt == ASP_RT_S1)
            next_s.smp[0] = line;
         if (s.rx_rt == ASP_RT_S2)
            next_s.smp[1] = line;
         if (s.rx_rt == ASP_RT_S3)
            next_s.smp[2] = line;
         case (s.rs)
            ASP_R_IDLE:
            begin
               if (!s.armed)
                  next_s.armed = line;
               else if (!line)
               begin
                  next_s.rs = ASP_R_START;
                  next_s.rx_rt = 4'h2;
                  next_s.vhigh = 2'h0;
                  next_s.rx_noise = 1'b0;
               end
            end
            ASP_R_START:
            begin
               if (s.rx_rt == ASP_RT_V1 || s.rx_rt == ASP_RT_V2
                  || s.rx_rt == ASP_RT_V3)
                  next_s.vhigh = s.vhigh + {1'b0, line};
               if (s.rx_rt == ASP_RT_V3)
               begin
                  if ((s.vhigh + {1'b0, line}) >= 2'h2)
                     next_s.rs = ASP_R_IDLE;
                  else if ((s.vhigh + {1'b0, line}) != 2'h0)
                     next_s.rx_noise = 1'b1;
               end
               if (s.rx_rt == ASP_RT_S3)
               begin
                  if (asp_major({line, s.smp[1:0]}))
                     next_s.rs = ASP_R_IDLE;
                  else if (line != s.smp[0] || line != s.smp[1])
                     next_s.rx_noise = 1'b1;
               end
               if (s.rx_rt == ASP_RT_LAST)
               begin
                  next_s.rs = ASP_R_BITS;
                  next_s.rx_bit = 4'h1;
               end
            end
            ASP_R_BITS:
            begin
               if (s.rx_rt == ASP_RT_S3)
               begin
                  maj = asp_major({line, s.smp[1:0]});
                  disagree = (line != s.smp[0]) || (line != s.smp[1]);
                  if (disagree)
                     next_s.rx_noise = 1'b1;
                  if (s.rx_bit != nbits - 4'h1)
                     next_s.rx_sh = {maj, s.rx_sh[8:1]};
                  else
                  begin
                     // Stop bit position reached
                     brk = !maj && (s.rx_sh == 9'h000)
                        && (nine || !s.rx_sh[8]);
                     accept = !s.ctrl2[ASP_C2_RWU];
                     if (s.ctrl2[ASP_C2_RWU] && s.ctrl1[ASP_C1_WAKE]
                        && s.rx_sh[8])
                     begin
                        next_s.ctrl2[ASP_C2_RWU] = 1'b0;
                        accept = 1'b1;
                     end
                     if (accept)
                     begin
                        next_s.idle_pend = 1'b1;
                        if (s.fl.rx_full_flag && next_s.fl.rx_full_flag)
                           next_s.fl.ovr = 1'b1;
                        else
                        begin
                           next_s.rx_data = nine ? s.rx_sh[7:0]
                              : s.rx_sh[8:1];
                           next_s.ctrl1[ASP_C1_R8] = s.rx_sh[8];
                           next_s.fl.rx_full_flag = 1'b1;
                           next_s.fl.nf = s.rx_noise || disagree;
                           next_s.fl.fe = !maj;
                        end
                     end
                     if (maj)
                        next_s.rs = ASP_R_IDLE;
                     else if (brk)
                     begin
                        next_s.rs = ASP_R_IDLE;
                        next_s.armed = 1'b0;
                     end
                     else
                        next_s.rs = ASP_R_FWAIT;
                  end
               end
               if (s.rx_rt == ASP_RT_LAST)
                  next_s.rx_bit = s.rx_bit + 4'h1;
            end
            ASP_R_FWAIT:
            begin
               // Qualifiers forced high: next start no earlier than due
               if (s.rx_rt == ASP_RT_LAST)
               begin
                  next_s.rs = ASP_R_IDLE;
                  next_s.armed = 1'b1;
               end
            end
            default:
               next_s.rs = ASP_R_IDLE;
         endcase
      end

      // Transmitter, bit step every sixteen sample ticks
      if (rt_tick)
         next_s.tx_rt = s.tx_rt + 4'h1;
      tx_go = s.ctrl2[ASP_C2_TE] && (!s.fl.tdre || s.ctrl2[ASP_C2_SBK]);
      if (!s.fl.tdre)
         tx_frame = {1'b1, nine ? s.ctrl1[ASP_C1_T8] : 1'b1, s.tx_data,
            1'b0};
      else
         tx_frame = 11'h000;
      case (s.ts)
         ASP_T_IDLE:
         begin
            next_s.tx_pin = 1'b1;
            if (tx_tick && tx_go)
            begin
               next_s.ts = ASP_T_SHIFT;
               next_s.tx_sh = tx_frame;
               next_s.tx_pin = tx_frame[0];
               next_s.tx_bit = 4'h0;
               next_s.fl.tdre = 1'b1;
            end
         end
         ASP_T_SHIFT:
         begin
            if (tx_tick)
            begin
               if (s.tx_bit == nbits - 4'h1)
               begin
                  if (tx_go)
                  begin
                     next_s.tx_sh = tx_frame;
                     next_s.tx_pin = tx_frame[0];
                     next_s.tx_bit = 4'h0;
                     next_s.fl.tdre = 1'b1;
                  end
                  else
                  begin
                     next_s.ts = ASP_T_IDLE;
                     next_s.tx_pin = 1'b1;
                     next_s.fl.tc = 1'b1;
                  end
               end
               else
               begin
                  next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
                  next_s.tx_pin = s.tx_sh[1];
                  next_s.tx_bit = s.tx_bit + 4'h1;
               end
            end
         end
         default:
            next_s.ts = ASP_T_IDLE;
      endcase

      // Interrupt output from four enables
      next_s.irq = (next_s.ctrl2[ASP_C2_TIE] && next_s.fl.tdre)
         || (next_s.ctrl2[ASP_C2_TCIE] && next_s.fl.tc)
         || (next_s.ctrl2[ASP_C2_RIE] && (next_s.fl.rx_full_flag || next_s.fl.ovr))
         || (next_s.ctrl2[ASP_C2_ILIE] && next_s.fl.idle);
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s <= '0;
         s.rx_s1 <= 1'b1;
         s.rx_s2 <= 1'b1;
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
         s.ctrl1 <= ASP_CTRL1_RST;
         s.ctrl2 <= ASP_CTRL2_RST;
         s.baud <= ASP_BAUD_RST;
         s.fl.tdre <= 1'b1;
         s.fl.tc <= 1'b1;
         s.rs <= ASP_R_IDLE;
         s.ts <= ASP_T_IDLE;
         s.tx_pin <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arready;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign serial_tx_pin = s.tx_pin;
   assign irq = s.irq;
endmodule : asp_top
`default_nettype wire

// >>> tb/asp_assertions.sv
// Checker of bus and serial line timing of the async serial port
`default_nettype none
module asp_assertions
(
   input wire logic ref_clk, // Clock
   input wire logic reset_n, // Reset, low
   input wire logic [asp_pkg::ASP_AW-1:0] s_axi_awaddr, // AW addr
   input wire logic s_axi_awvalid, // AW valid
   input wire logic s_axi_awready, // AW ready
   input wire logic s_axi_wvalid, // W valid
   input wire logic s_axi_wready, // W ready
   input wire logic [1:0] s_axi_bresp, // B resp
   input wire logic s_axi_bvalid, // B valid
   input wire logic s_axi_bready, // B ready
   input wire logic s_axi_arvalid, // AR valid
   input wire logic s_axi_arready, // AR ready
   input wire logic [31:0] s_axi_rdata, // R data
   input wire logic s_axi_rvalid, // R valid
   input wire logic s_axi_rready, // R ready
   input wire logic serial_tx_pin // Tx line
);
   timeunit 1ns;
   timeprecision 1ns;
   import asp_pkg::*;
   logic bad_aw;
   // Remembers whether the last write address hit no register
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         bad_aw <= 1'b0;
      else if (s_axi_awvalid && s_axi_awready)
         bad_aw <= s_axi_awaddr[1:0] != 2'h0 || s_axi_awaddr > ASP_OFS_BAUD;
   end
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   tx_idle_a: assert property (
      $rose(reset_n) |-> serial_tx_pin) else $error("tx not idle");
   tx_start_a: assert property (
      $fell(serial_tx_pin) |-> !serial_tx_pin[*8] ##1 !serial_tx_pin[*8])
      else $error("low bit too short");
   tx_high_a: assert property (
      $rose(serial_tx_pin) |-> serial_tx_pin[*8] ##1 serial_tx_pin[*8])
      else $error("high bit too short");
   b_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid) else $error("no write answer");
   b_stands_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   b_code_a: assert property (
      s_axi_bvalid |-> s_axi_bresp == (bad_aw ? 2'h2 : 2'h0))
      else $error("wrong write response");
   r_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   r_stands_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   r_width_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   cover property (s_axi_bvalid && bad_aw);
   cover property ($fell(serial_tx_pin));
   cover property (s_axi_rvalid && s_axi_rready);
endmodule : asp_assertions
`default_nettype wire

// >>> tb/asp_far_port.sv
// Far-end serial port model, one bit per 16 clocks
`default_nettype none
module asp_far_port
(
   input wire logic ref_clk, // Clock
   input wire logic line_in, // Design tx line
   output logic line_out // Design rx line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got = 8'h00;
   logic got_stop = 1'b0;
   int got_n = 0;
   initial line_out = 1'b1;
   // Glitch flips the middle sample clock (RT9) of bit index g
   task automatic send(input logic [7:0] d, input logic stp, input int g);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int i = 0; i < 10; i++)
         for (int c = 0; c < 16; c++)
         begin
            @(posedge ref_clk);
            line_out <= (i == g && c == 8) ? ~f[i] : f[i];
         end
      @(posedge ref_clk);
      line_out <= 1'b1;
      repeat (16) @(posedge ref_clk);
   endtask : send
   always
   begin
      @(negedge line_in);
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (16) @(posedge ref_clk);
         got[i] = line_in;
      end
      repeat (16) @(posedge ref_clk);
      got_stop = line_in;
      got_n++;
   end
endmodule : asp_far_port
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the async serial port
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import asp_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ASP_AW-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awrdy, wrdy, bvalid, arrdy, rvalid, rx_line, tx_line, irq;
   logic [31:0] wdata = '0, rdata;
   logic [1:0] bresp, rresp;
   logic [7:0] td [5] = '{8'h96, 8'h5A, 8'h55, 8'h00, 8'hC3};
   logic [7:0] ts [5] = '{8'h24, 8'h24, 8'h22, 8'h22, 8'h20};
   int tg [5] = '{3, 0, -1, -1, -1};
   int err_total = 0, n_compared = 0, cyc = 0;
   always #50 ref_clk = ~ref_clk;
   asp_top asp_top_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .serial_rx_pin(rx_line), .serial_tx_pin(tx_line), .irq(irq));
   asp_far_port asp_far_port_inst (.ref_clk(ref_clk), .line_in(tx_line),
      .line_out(rx_line));
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [1:0] r;
      r = (a[1:0] != 2'h0 || a > ASP_OFS_BAUD) ? ASP_RESP_SLVERR : 2'h0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            do @(posedge ref_clk); while (awrdy !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge ref_clk); while (wrdy !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({6'h00, bresp}, {6'h00, r});
   endtask : wr
   task automatic rc(input logic [4:0] a, input logic [7:0] e, m);
      logic [1:0] r;
      r = (a > ASP_OFS_BAUD) ? ASP_RESP_SLVERR : ASP_RESP_OKAY;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge ref_clk); while (arrdy !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata[7:0] & m, e);
      chk({6'h00, rresp}, {6'h00, r});
   endtask : rc
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 12000)
      begin
         err_total++;
         $display("[ERR] %0t run too long", $time);
         print_verdict();
      end
   end
   initial
   begin
      int n0;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      rc(ASP_OFS_STATUS, 8'hC0, 8'hFE);
      rc(ASP_OFS_CTRL1, 8'h00, 8'h7F);
      rc(ASP_OFS_CTRL2, 8'h00, 8'hFF);
      rc(ASP_OFS_BAUD, 8'h00, 8'h1F);
      rc(5'h14, 8'h00, 8'hFF);
      wr(5'h18, 8'h55);
      $display("test map done");
      wr(ASP_OFS_CTRL2, 8'h88);
      repeat (3) @(posedge ref_clk);
      chk({7'h00, irq}, 8'h01);
      wr(ASP_OFS_CTRL2, 8'h0C);
      repeat (3) @(posedge ref_clk);
      chk({7'h00, irq}, 8'h00);
      $display("test interrupt done");
      n0 = asp_far_port_inst.got_n;
      fork
         wr(ASP_OFS_DATA, 8'hA5);
         asp_far_port_inst.send(8'h3C, 1'b1, -1);
      join
      for (int i = 0; i < 600 && asp_far_port_inst.got_n == n0; i++)
         @(posedge ref_clk);
      repeat (16) @(posedge ref_clk);
      chk(asp_far_port_inst.got, 8'hA5);
      chk({7'h00, asp_far_port_inst.got_stop}, 8'h01);
      rc(ASP_OFS_STATUS, 8'hE0, 8'hE6);
      rc(ASP_OFS_DATA, 8'h3C, 8'hFF);
      rc(ASP_OFS_STATUS, 8'h00, 8'h20);
      $display("test duplex done");
      for (int k = 0; k < 5; k++)
      begin
         asp_far_port_inst.send(td[k], ts[k][2] | ~ts[k][1], tg[k]);
         rc(ASP_OFS_STATUS, ts[k], 8'h2E);
         rc(ASP_OFS_DATA, td[k], 8'hFF);
         wr(ASP_OFS_STATUS, 8'h06);
      end
      $display("test errors done");
      asp_far_port_inst.send(8'h11, 1'b1, -1);
      asp_far_port_inst.send(8'h22, 1'b1, -1);
      rc(ASP_OFS_STATUS, 8'h28, 8'h2E);
      rc(ASP_OFS_DATA, 8'h11, 8'hFF);
      $display("test overrun done");
      wr(ASP_OFS_CTRL2, 8'h0E);
      asp_far_port_inst.send(8'h33, 1'b1, -1);
      rc(ASP_OFS_STATUS, 8'h00, 8'h20);
      repeat (150) @(posedge ref_clk);
      rc(ASP_OFS_CTRL2, 8'h0C, 8'hFF);
      wr(ASP_OFS_CTRL1, 8'h08);
      wr(ASP_OFS_CTRL2, 8'h0E);
      asp_far_port_inst.send(8'h01, 1'b1, -1);
      rc(ASP_OFS_STATUS, 8'h00, 8'h20);
      asp_far_port_inst.send(8'h81, 1'b1, -1);
      rc(ASP_OFS_DATA, 8'h81, 8'hFF);
      rc(ASP_OFS_CTRL2, 8'h0C, 8'hFF);
      $display("test wake done");
      print_verdict();
   end
endmodule : tb_top
bind asp_top asp_assertions asp_assertions_inst (.ref_clk(ref_clk),
   .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .serial_tx_pin(serial_tx_pin));
`default_nettype wire
